// *** design/rsis_seq.sv ***
// Reset, strap sampling, self-test, boot checksum and bad-access handling.
// Assumes the board delivers a clock-aligned reset pin; self-test is modelled by inputs.
`timescale 1ns/1ps
module rsis_seq
   import rsis_pkg::*;
#(
   parameter int unsigned TEST_W = 16      // Width of the self-test length input
) (
   input wire logic mclk_i,                  // Double-rate clock, 250 MHz
   input wire logic rst_n_i,                 // Block reset, synchronous, active low
   input wire logic reset_pin_i,             // Processor reset pin, active high
   input wire logic irq0_msg_pin_i,          // Interrupt/message pin, strap at release
   input wire logic bad_access_in_i,         // Bad access pin, strap at release
   input wire logic selftest_pass_i,         // Self-test outcome, 1 = pass
   input wire logic [TEST_W-1:0] selftest_cycles_i, // Self-test length in cycles
   input wire logic [31:0] fetch_data_i,     // Boot word returned
   input wire logic fetch_ack_i,             // Boot word valid
   input wire logic last_ready_i,            // Last ready of a transfer, same clock
   input wire logic sync_op_i,               // Transfer belongs to a sync move or load
   output logic failure_o,                   // Failure pin drive level, always low
   output logic failure_oe_o,                // Failure pin pulled low while high
   output logic fetch_req_o,                 // Boot word request
   output logic [31:0] fetch_addr_o,         // Boot word address
   output logic proc_num_o,                  // Processor number, 0 or 1
   output logic primary_master_o,            // Strapped as primary master
   output logic secondary_master_o,          // Strapped as secondary master
   output logic init_leader_o,               // Strapped to run active initialization
   output logic [31:0] boot_ptr_a_o,         // First data-structure pointer
   output logic [31:0] boot_ptr_b_o,         // Second data-structure pointer
   output logic irq_clear_o,                 // Clear latched interrupts, pulse
   output logic run_o,                       // Executing instructions
   output logic stopped_o,                   // Stopped state
   output logic outputs_en_o,                // Bus outputs may be driven
   output logic err_unrecov_o,               // Unrecoverable bad access seen
   output logic err_recov_o                  // Recoverable bad access seen
);
   rsis_state_t state_q, state_d;
   logic rst_pin_s, strap_irq_s, bad_s;
   logic [5:0] rst_cnt_q;
   logic [1:0] fdly_q;
   logic [TEST_W-1:0] test_cnt_q;
   logic [2:0] widx_q;
   logic [31:0] sum_q;
   logic [31:0] words_q [BOOT_WORDS];
   logic lr_q, syn_q;
   logic test_done, release_ok;

   // All three pins cross from the board, so they share one filter
   rsis_pin_sync #(.W(3)) u_sync (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .pin_i({reset_pin_i, irq0_msg_pin_i, bad_access_in_i}),
      .lvl_o({rst_pin_s, strap_irq_s, bad_s})
   );

   assign release_ok = !rst_pin_s && (rst_cnt_q >= 6'(RESET_MIN_CYC));
   assign test_done = (test_cnt_q + TEST_W'(1)) >= selftest_cycles_i;

   // Count how long reset is held; a short pulse must be reasserted in full
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rst_cnt_q <= '0;
      end else if (state_q != RSIS_HOLD) begin
         rst_cnt_q <= rst_pin_s ? 6'h01 : 6'h00;
      end else if (rst_pin_s) begin
         if (rst_cnt_q < 6'(RESET_MIN_CYC)) rst_cnt_q <= rst_cnt_q + 6'h01;
      end else if (!release_ok) begin
         rst_cnt_q <= '0;
      end
   end

   // Sequencer; the synchronised reset pin, while high, preempts every state
   always_comb begin
      state_d = state_q;
      case (state_q)
         RSIS_HOLD:  if (release_ok) state_d = RSIS_FDLY;
         RSIS_FDLY:  if (fdly_q == 2'(FAIL_DLY_CYC - 1)) state_d = RSIS_TEST;
         RSIS_TEST: begin
            if (test_done) begin
               if (!selftest_pass_i) state_d = RSIS_STOP;
               else if (init_leader_o) state_d = RSIS_FETCH;
               else state_d = RSIS_CLRQ;
            end
         end
         RSIS_FETCH: if (fetch_ack_i && widx_q == BOOT_LAST_IDX) state_d = RSIS_CHECK;
         RSIS_CHECK: state_d = (sum_q == BOOT_SUM_OK) ? RSIS_CLRQ : RSIS_STOP;
         RSIS_CLRQ:  state_d = RSIS_RUN;
         RSIS_RUN:   state_d = RSIS_RUN;
         RSIS_STOP:  state_d = RSIS_STOP;
         default:    state_d = RSIS_HOLD;
      endcase
      if (rst_pin_s) state_d = RSIS_HOLD;
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) state_q <= RSIS_HOLD;
      else state_q <= state_d;
   end

   // Failure follows the next state, so it is held through test and stop
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) failure_oe_o <= 1'b0;
      else failure_oe_o <= (state_d == RSIS_TEST) || (state_d == RSIS_STOP);
   end
   assign failure_o = 1'b0;

   // Straps are caught on the cycle the valid release is seen
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         proc_num_o <= 1'b0;
         init_leader_o <= 1'b0;
      end else if (state_q == RSIS_HOLD && release_ok) begin
         proc_num_o <= !strap_irq_s;
         init_leader_o <= bad_s;
      end
   end
   assign primary_master_o = !proc_num_o;
   assign secondary_master_o = proc_num_o;

   // Failure delay and self-test cycle counters
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fdly_q <= '0;
         test_cnt_q <= '0;
      end else begin
         fdly_q <= (state_q == RSIS_FDLY) ? fdly_q + 2'h1 : 2'h0;
         test_cnt_q <= (state_q == RSIS_TEST) ? test_cnt_q + TEST_W'(1) : '0;
      end
   end

   // Boot fetch: one outstanding request, address held in a flop
   assign fetch_req_o = (state_q == RSIS_FETCH);
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         widx_q <= '0;
         sum_q <= '0;
         fetch_addr_o <= BOOT_BASE;
      end else if (state_q != RSIS_FETCH) begin
         widx_q <= '0;
         sum_q <= '0;
         fetch_addr_o <= BOOT_BASE;
      end else if (fetch_ack_i) begin
         words_q[widx_q] <= fetch_data_i;
         sum_q <= sum_q + fetch_data_i;
         widx_q <= widx_q + 3'h1;
         fetch_addr_o <= BOOT_BASE + {27'h0, widx_q + 3'h1, BYTE_SHIFT};
      end
   end

   // Pointers reuse words already fetched; no second bus access is needed
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         boot_ptr_a_o <= '0;
         boot_ptr_b_o <= '0;
      end else if (state_q == RSIS_CHECK && sum_q == BOOT_SUM_OK) begin
         boot_ptr_a_o <= words_q[BOOT_PTR_A_IDX];
         boot_ptr_b_o <= words_q[BOOT_PTR_B_IDX];
      end
   end

   assign irq_clear_o = (state_q == RSIS_CLRQ);
   assign run_o = (state_q == RSIS_RUN);
   assign stopped_o = (state_q == RSIS_STOP);
   assign outputs_en_o = !(state_q == RSIS_HOLD || state_q == RSIS_STOP);

   // Bad access is looked at one cycle after the last ready; set beats clear
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         lr_q <= 1'b0;
         syn_q <= 1'b0;
         err_unrecov_o <= 1'b0;
         err_recov_o <= 1'b0;
      end else begin
         lr_q <= last_ready_i && outputs_en_o;
         syn_q <= sync_op_i;
         if (lr_q && bad_s && !syn_q) err_unrecov_o <= 1'b1;
         else if (state_q == RSIS_HOLD) err_unrecov_o <= 1'b0;
         if (lr_q && bad_s && syn_q) err_recov_o <= 1'b1;
         else if (state_q == RSIS_HOLD) err_recov_o <= 1'b0;
      end
   end

   // Checks on the sequence
   a_reset_short: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_HOLD && !rst_pin_s && rst_cnt_q < 6'(RESET_MIN_CYC)) |=> state_q == RSIS_HOLD)
      else $error("Init began after a short reset");
   a_strap_number: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_HOLD && release_ok) |=> primary_master_o == $past(strap_irq_s))
      else $error("Processor number strap not captured");
   a_strap_leader: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_HOLD && release_ok) |=> init_leader_o == $past(bad_s))
      else $error("Leader strap not captured");
   a_fail_soon: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_HOLD && release_ok && !reset_pin_i) ##1 !rst_pin_s [*3]
      |-> ##[0:1] failure_oe_o)
      else $error("Failure not asserted after release");
   a_test_fail_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_q == RSIS_TEST |-> failure_oe_o)
      else $error("Failure dropped during self-test");
   a_test_stop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_TEST && test_done && !selftest_pass_i && !rst_pin_s)
      |=> stopped_o && failure_oe_o && !outputs_en_o)
      else $error("Self-test fault did not stop");
   a_test_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_TEST && test_done && selftest_pass_i && !rst_pin_s) |=> !failure_oe_o)
      else $error("Failure held after a passing self-test");
   a_fetch_addr: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      fetch_req_o |-> fetch_addr_o == BOOT_BASE + {27'h0, widx_q, BYTE_SHIFT})
      else $error("Boot fetch address wrong");
   a_sum_stop: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (state_q == RSIS_CHECK && sum_q != BOOT_SUM_OK && !rst_pin_s) |=> stopped_o && failure_oe_o)
      else $error("Bad checksum did not stop");
   a_irq_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      $rose(run_o) |-> $past(irq_clear_o))
      else $error("Run began without clearing interrupts");
   a_bad_unrecov: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (last_ready_i && outputs_en_o && !sync_op_i) ##1 (bad_s && state_q != RSIS_HOLD)
      |=> err_unrecov_o)
      else $error("Bad access not flagged unrecoverable");
   a_bad_recov: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (last_ready_i && outputs_en_o && sync_op_i) ##1 bad_s |=> err_recov_o)
      else $error("Bad access after sync op not recoverable");
   a_reset_quiet: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      rst_pin_s |=> !fetch_req_o && !outputs_en_o && !failure_oe_o)
      else $error("Activity while reset asserted");

   c_boot_run: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_q == RSIS_CHECK ##1 run_o [*2]);
   c_test_stop: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_q == RSIS_TEST ##1 stopped_o);
   c_sum_stop: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
      state_q == RSIS_CHECK ##1 stopped_o);
   c_recov: cover property (@(posedge mclk_i) disable iff (!rst_n_i) $rose(err_recov_o));
endmodule : rsis_seq

// *** design/rsis_pkg.sv ***
// Constants, state encoding and field layout for the reset and init sequencer.
// Assumes one clock, the double-rate clock, and a synchronous active-low block reset.
package rsis_pkg;
   localparam int unsigned RESET_MIN_CYC = 41;     // Least reset length, double-rate cycles
   localparam int unsigned FAIL_DLY_CYC = 3;       // Cycles from release to failure assert
   localparam int unsigned BOOT_WORDS = 8;         // Words in the boot checksum block
   localparam logic [31:0] BOOT_BASE = 32'h0000_0000;
   localparam logic [31:0] BOOT_SUM_OK = 32'h0000_0000;  // Sum of eight words when good
   localparam logic [2:0] BOOT_PTR_A_IDX = 3'h1;  // Boot word used as first pointer
   localparam logic [2:0] BOOT_PTR_B_IDX = 3'h2;  // Boot word used as second pointer
   localparam logic [2:0] BOOT_LAST_IDX = 3'h7;
   localparam logic [1:0] BYTE_SHIFT = 2'h0;       // Low address bits of a word address

   typedef enum logic [2:0] {
      RSIS_HOLD  = 3'h0,   // Reset pin asserted or not yet validly released
      RSIS_FDLY  = 3'h1,   // Few cycles before failure asserts
      RSIS_TEST  = 3'h2,   // Self-test running, failure asserted
      RSIS_FETCH = 3'h3,   // Fetching boot words
      RSIS_CHECK = 3'h4,   // Comparing boot checksum
      RSIS_CLRQ  = 3'h5,   // One cycle to drop latched interrupts
      RSIS_RUN   = 3'h6,   // Executing
      RSIS_STOP  = 3'h7    // Stopped, does nothing until reset
   } rsis_state_t;
endpackage : rsis_pkg

// *** design/rsis_pin_sync.sv ***
// Three-stage synchroniser for pins arriving from outside the clock domain.
// Assumes each bit is an independent level; output moves only when stages two and three agree.
`timescale 1ns/1ps
module rsis_pin_sync #(
   parameter int unsigned W = 1
) (
   input wire logic mclk_i,             // Double-rate clock
   input wire logic rst_n_i,            // Synchronous reset, active low
   input wire logic [W-1:0] pin_i,      // Raw pin levels
   output logic [W-1:0] lvl_o           // Filtered levels
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;

   // First stage feeds only the second, so metastability never reaches a gate
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // A change counts once the later two stages agree, which rejects one-cycle glitches
   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         always_ff @(posedge mclk_i) begin
            if (!rst_n_i) begin
               lvl_o[g] <= 1'b0;
            end else if (s2_q[g] == s3_q[g]) begin
               lvl_o[g] <= s3_q[g];
            end
         end
      end
   endgenerate
endmodule : rsis_pin_sync

// *** tb/rsis_board_model.sv ***
// Board-side partner: user reset synchroniser and boot memory on the local bus.
// Assumes the sequencer holds a word request and takes the word on the ack edge.
`timescale 1ns/1ps
module rsis_board_model (
   input wire logic mclk_i,              // Double-rate clock
   input wire logic user_rst_i,          // Raw user reset, active high
   input wire logic one_flop_i,          // User reset already on this clock
   input wire logic slow_i,              // Wait cycles after each word
   input wire logic bad_sum_i,           // Corrupt the last boot word
   input wire logic fetch_req_i,         // Word request
   input wire logic [31:0] fetch_addr_i, // Word address
   output logic reset_pin_o,             // Processor reset pin
   output logic [31:0] fetch_data_o,     // Word, churns when not acked
   output logic fetch_ack_o              // Word valid pulse
);
   logic sync_q = 1'b1;
   logic rst_q = 1'b1;
   logic ack_q = 1'b0;
   logic [1:0] wait_q = 2'h0;
   logic [31:0] data_q = 32'h5a5a_c3c3;
   logic [2:0] idx;
   // A reset that is already clock-aligned skips the second flop
   assign reset_pin_o = one_flop_i ? sync_q : rst_q;
   assign fetch_ack_o = ack_q;
   assign fetch_data_o = data_q;
   assign idx = fetch_addr_i[4:2];
   // Two flops on the rising edge, so release lands just after an edge A
   always @(posedge mclk_i) begin
      sync_q <= user_rst_i;
      rst_q <= sync_q;
   end
   // Words are index plus one; the last cancels the sum so a good block adds to zero
   always @(posedge mclk_i) begin
      ack_q <= 1'b0;
      data_q <= ~data_q; // Released bus alternates between the last word and its inverse
      if (fetch_req_i && !ack_q) begin
         if (wait_q != 2'h0) begin
            wait_q <= wait_q - 2'h1;
         end else begin
            ack_q <= 1'b1;
            data_q <= (idx == 3'h7) ? 32'hffff_ffe4 + {31'h0, bad_sum_i} : {29'h0, idx} + 32'h1;
            wait_q <= slow_i ? 2'h3 : 2'h0;
         end
      end
   end
endmodule : rsis_board_model

// *** tb/rsis_seq_test.sv ***
// Self-checking bench: boots the sequencer through pass, stop and abort paths.
// Assumes the board model supplies reset and boot words; straps come from here.
`timescale 1ns/1ps
module rsis_seq_test;
   import rsis_pkg::*;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic user_rst = 1'b1, slow = 1'b0, bad_sum = 1'b0, one_flop = 1'b0;
   logic irq0_msg_pin_i = 1'b1, bad_access_in_i = 1'b1, selftest_pass_i = 1'b1;
   logic [15:0] selftest_cycles_i = 16'h0005;
   logic last_ready_i = 1'b0, sync_op_i = 1'b0;
   logic reset_pin_i, fetch_ack_i, fetch_req_o;
   logic [31:0] fetch_data_i, fetch_addr_o, boot_ptr_a_o, boot_ptr_b_o;
   logic failure_o, failure_oe_o, proc_num_o, primary_master_o, secondary_master_o;
   logic init_leader_o, irq_clear_o, run_o, stopped_o, outputs_en_o, err_unrecov_o, err_recov_o;
   logic [7:0] exp_q[$];
   logic [4:0] cfg[6] = '{5'h18, 5'h1d, 5'h08, 5'h14, 5'h1a, 5'h01};
   logic done_q = 1'b0, clr_seen = 1'b0;
   int n_mismatch = 0, checks_done = 0;
   logic [31:0] rnd = 32'h0000_0048;
   always #2 mclk_i = ~mclk_i;
   rsis_board_model board_u (.mclk_i, .user_rst_i(user_rst), .one_flop_i(one_flop), .slow_i(slow),
      .bad_sum_i(bad_sum), .fetch_req_i(fetch_req_o), .fetch_addr_i(fetch_addr_o),
      .reset_pin_o(reset_pin_i), .fetch_data_o(fetch_data_i), .fetch_ack_o(fetch_ack_i));
   rsis_seq #(.TEST_W(16)) dut_u (.mclk_i, .rst_n_i, .reset_pin_i, .irq0_msg_pin_i,
      .bad_access_in_i, .selftest_pass_i, .selftest_cycles_i, .fetch_data_i, .fetch_ack_i,
      .last_ready_i, .sync_op_i, .failure_o, .failure_oe_o, .fetch_req_o, .fetch_addr_o,
      .proc_num_o, .primary_master_o, .secondary_master_o, .init_leader_o, .boot_ptr_a_o,
      .boot_ptr_b_o, .irq_clear_o, .run_o, .stopped_o, .outputs_en_o, .err_unrecov_o,
      .err_recov_o);
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   // Scores each boot as it settles; the clear pulse has to come before run
   always @(posedge mclk_i) begin
      if (reset_pin_i === 1'b1) clr_seen <= 1'b0;
      else if (irq_clear_o === 1'b1) clr_seen <= 1'b1;
      if ((run_o | stopped_o) === 1'b1 && done_q === 1'b0 && exp_q.size() > 0) begin
         chk("outcome", {stopped_o, failure_oe_o, proc_num_o, primary_master_o, secondary_master_o,
            init_leader_o, outputs_en_o, clr_seen}, exp_q.pop_front());
         chk("fail_drive", failure_o, 0);
      end
      done_q <= run_o | stopped_o;
   end
   // One full boot; straps stay put until the outcome is in
   task automatic boot(input logic [4:0] c, input logic pn);
      logic stop;
      int i;
      stop = !c[3] || (c[4] && c[2]);
      @(posedge mclk_i);
      irq0_msg_pin_i <= pn;
      bad_access_in_i <= c[4];
      selftest_pass_i <= c[3];
      selftest_cycles_i <= {13'h0, rnd[2:0]} + 16'h1;
      bad_sum <= c[2];
      slow <= c[1];
      one_flop <= c[0];
      user_rst <= 1'b1;
      exp_q.push_back({stop, stop, !pn, pn, !pn, c[4], !stop, !stop});
      repeat (RESET_MIN_CYC + 8) @(posedge mclk_i);
      user_rst <= 1'b0;
      for (i = 0; i < 20 && failure_oe_o !== 1'b1; i++) @(posedge mclk_i);
      chk("fail_on", failure_oe_o, 1);
      if (c[4] && c[3]) begin
         for (i = 0; i < 100 && fetch_req_o !== 1'b1; i++) @(posedge mclk_i);
         chk("fetch_state", {fetch_req_o, failure_oe_o}, 2'h2);
         chk("fetch_base", fetch_addr_o, BOOT_BASE);
      end
      for (i = 0; i < 400 && (run_o | stopped_o) !== 1'b1; i++) @(posedge mclk_i);
      @(posedge mclk_i);
      chk("settled", run_o | stopped_o, 1);
      if (!stop && c[4]) begin
         chk("ptr_a", boot_ptr_a_o, {29'h0, BOOT_PTR_A_IDX} + 32'h1);
         chk("ptr_b", boot_ptr_b_o, {29'h0, BOOT_PTR_B_IDX} + 32'h1);
      end
      bad_access_in_i <= 1'b0;
      $display("test boot cfg %h pn %0b done", c, pn);
   endtask : boot
   // Bad pin raised early; nothing counts until the cycle after last ready
   task automatic bad_xfer(input logic syn);
      @(posedge mclk_i);
      bad_access_in_i <= 1'b1;
      repeat (5) @(posedge mclk_i);
      chk("no_ready", {err_unrecov_o, err_recov_o}, {syn, 1'b0});
      last_ready_i <= 1'b1;
      sync_op_i <= syn;
      @(posedge mclk_i);
      last_ready_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      bad_access_in_i <= 1'b0;
      #1;
      chk("err_flags", {err_unrecov_o, err_recov_o}, 2'h3 - {1'b0, !syn});
      $display("test bad access sync %0b done", syn);
   endtask : bad_xfer
   initial begin
      #(4 * 20000);
      n_mismatch++;
      test_done();
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      boot(cfg[0], 1'b1);
      bad_xfer(1'b0);
      bad_xfer(1'b1);
      // Short reset pulse: outputs quiet at once, then the release is refused
      @(posedge mclk_i);
      user_rst <= 1'b1;
      repeat (10) @(posedge mclk_i);
      #1;
      chk("quiet", {run_o, outputs_en_o, failure_oe_o, err_unrecov_o}, 0);
      @(posedge mclk_i);
      user_rst <= 1'b0;
      repeat (100) @(posedge mclk_i);
      #1;
      chk("short_rst", {run_o, failure_oe_o, stopped_o}, 0);
      $display("test short reset done");
      for (int k = 1; k < 6; k++) begin
         rnd = xs(rnd);
         boot(cfg[k], rnd[7]);
      end
      test_done();
   end
endmodule : rsis_seq_test
